/* logic/ssl_pkg.sv */
package ssl_pkg;

  // ****************************************
  // Unit states
  // ****************************************
  typedef enum logic [1:0] {
    SSL_OFF  = 2'h0,
    SSL_NORM = 2'h1,
    SSL_FULL = 2'h3
  } ssl_unit_e;

  // ****************************************
  // Power state machine
  // ****************************************
  typedef enum logic [1:0] {
    SSL_ACTIVE = 2'h0,
    SSL_SLEEP  = 2'h1,
    SSL_WAKE   = 2'h3
  } ssl_pwr_e;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ        = 200;
  localparam int SETTLE_NS      = 2000;
  localparam int SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_FAST_NS   = 2000;
  localparam int WAKE_FAST_CYC  = (WAKE_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_SLOW_US   = 150;
  localparam int WAKE_SLOW_CYC  = WAKE_SLOW_US * CLK_MHZ;
  localparam int CNT_W          = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

endpackage

/* logic/ssl_supervisor_lpm.sv */
`timescale 1ns/1ps

module ssl_supervisor_lpm #(
  parameter int SETTLE_CYCLES    = ssl_pkg::SETTLE_CYC,
  parameter int WAKE_SLOW_CYCLES = ssl_pkg::WAKE_SLOW_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic soft_power_up_clear,
  // Low side control
  input  wire logic low_side_ctrl_wr,
  input  wire logic low_supervisor_enable,
  input  wire logic low_supervisor_sleep_keep,
  input  wire logic low_supervisor_full_perf,
  input  wire logic low_monitor_enable,
  input  wire logic low_monitor_full_perf,
  input  wire logic low_side_auto_control,
  // High side control
  input  wire logic high_side_ctrl_wr,
  input  wire logic high_supervisor_enable,
  input  wire logic high_supervisor_sleep_keep,
  input  wire logic high_supervisor_full_perf,
  input  wire logic high_monitor_enable,
  input  wire logic high_monitor_full_perf,
  input  wire logic high_side_auto_control,
  input  wire logic overvoltage_protect_enable,
  // Power mode requests and events
  input  wire logic sleep_request,
  input  wire logic isr_return_sleep,
  input  wire logic wake_interrupt,
  input  wire logic overvoltage_pin,
  // Status
  output logic       low_side_delay_flag,
  output logic       high_side_delay_flag,
  output logic       deep_sleep_state,
  output logic       cpu_hold,
  output logic       slow_wake,
  output logic       hang_config,
  output logic       por_request,
  output logic [1:0] low_sup_state,
  output logic [1:0] low_mon_state,
  output logic [1:0] high_sup_state,
  output logic [1:0] high_mon_state
);

  localparam int CNT_W_L = ssl_pkg::CNT_W;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [CNT_W_L-1:0] lo_cnt;
    logic [CNT_W_L-1:0] hi_cnt;
    logic               lo_flag;
    logic               hi_flag;
    ssl_pkg::ssl_pwr_e  pwr;
    logic [CNT_W_L-1:0] wake_cnt;
    logic               slow;
    logic               hang;
    logic               por;
    logic [1:0]         ls, lm, hs, hm;
    logic               ov_m, ov_s;
  } ssl_state_s;

  ssl_state_s st_r;
  ssl_state_s st_nxt;

  // ****************************************
  // Unit state helpers
  // ****************************************
  function automatic logic [1:0] act_st(input logic en, input logic fp);
    act_st = !en ? ssl_pkg::SSL_OFF : (fp ? ssl_pkg::SSL_FULL
                                          : ssl_pkg::SSL_NORM);
  endfunction

  function automatic logic [1:0] slp_st(input logic en, input logic fp,
                                        input logic keep,
                                        input logic aut);
    logic [1:0] a;
    a = act_st(en, fp);
    if (!keep)
      slp_st = ssl_pkg::SSL_OFF;
    else if (aut)
      slp_st = (a == ssl_pkg::SSL_FULL) ? ssl_pkg::SSL_NORM
                                        : ssl_pkg::SSL_OFF;
    else
      slp_st = a;
  endfunction

  // ****************************************
  // Derived configuration
  // ****************************************
  logic lo_fast;
  logic hi_off_on_entry;
  logic enter_req;
  logic clr;

  always_comb
  begin
    lo_fast = !low_supervisor_enable || low_supervisor_full_perf ||
              !low_monitor_enable || low_monitor_full_perf;
    hi_off_on_entry =
      (high_supervisor_enable && !high_supervisor_full_perf &&
       (!high_supervisor_sleep_keep || high_side_auto_control)) ||
      (high_monitor_enable && !high_monitor_full_perf &&
       high_side_auto_control);
    enter_req = sleep_request || isr_return_sleep;
    clr = srst || soft_power_up_clear;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ov_m = overvoltage_pin;
    st_nxt.ov_s = st_r.ov_m;
    // Settling delay flags
    if (low_side_ctrl_wr)
    begin
      st_nxt.lo_flag = 1'b1;
      st_nxt.lo_cnt  = CNT_W_L'(SETTLE_CYCLES);
    end
    else if (st_r.lo_cnt != '0)
      st_nxt.lo_cnt = st_r.lo_cnt - 1'b1;
    else
      st_nxt.lo_flag = 1'b0;
    if (high_side_ctrl_wr)
    begin
      st_nxt.hi_flag = 1'b1;
      st_nxt.hi_cnt  = CNT_W_L'(SETTLE_CYCLES);
    end
    else if (st_r.hi_cnt != '0)
      st_nxt.hi_cnt = st_r.hi_cnt - 1'b1;
    else
      st_nxt.hi_flag = 1'b0;
    st_nxt.slow = low_supervisor_enable && !low_supervisor_full_perf;
    st_nxt.hang = lo_fast && hi_off_on_entry;
    st_nxt.por  = overvoltage_protect_enable && high_monitor_enable &&
                  (st_r.hm != ssl_pkg::SSL_OFF) && st_r.ov_s;
    // Power sequence
    unique case (st_r.pwr)
      ssl_pkg::SSL_ACTIVE:
      begin
        st_nxt.ls = act_st(low_supervisor_enable, low_supervisor_full_perf);
        st_nxt.lm = act_st(low_monitor_enable, low_monitor_full_perf);
        st_nxt.hs = act_st(high_supervisor_enable,
                           high_supervisor_full_perf);
        st_nxt.hm = act_st(high_monitor_enable, high_monitor_full_perf);
        if (enter_req && !wake_interrupt)
        begin
          st_nxt.pwr = ssl_pkg::SSL_SLEEP;
          st_nxt.ls = slp_st(low_supervisor_enable,
                             low_supervisor_full_perf,
                             low_supervisor_sleep_keep,
                             low_side_auto_control);
          st_nxt.lm = slp_st(low_monitor_enable, low_monitor_full_perf,
                             !low_side_auto_control ||
                             low_monitor_full_perf,
                             low_side_auto_control);
          st_nxt.hs = slp_st(high_supervisor_enable,
                             high_supervisor_full_perf,
                             high_supervisor_sleep_keep,
                             high_side_auto_control);
          st_nxt.hm = high_side_auto_control ? ssl_pkg::SSL_OFF
                    : act_st(high_monitor_enable, high_monitor_full_perf);
        end
      end
      ssl_pkg::SSL_SLEEP:
        if (wake_interrupt)
        begin
          st_nxt.pwr = ssl_pkg::SSL_WAKE;
          st_nxt.wake_cnt = st_r.slow ? CNT_W_L'(WAKE_SLOW_CYCLES)
                                      : CNT_W_L'(ssl_pkg::WAKE_FAST_CYC);
        end
      ssl_pkg::SSL_WAKE:
        if (st_r.wake_cnt <= CNT_W_L'(1))
          st_nxt.pwr = ssl_pkg::SSL_ACTIVE;
        else
          st_nxt.wake_cnt = st_r.wake_cnt - 1'b1;
      default:
        st_nxt.pwr = ssl_pkg::SSL_ACTIVE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      st_r          <= '0;
      st_r.pwr      <= ssl_pkg::SSL_ACTIVE;
      st_r.lo_cnt   <= ssl_pkg::CNT_RST;
      st_r.hi_cnt   <= ssl_pkg::CNT_RST;
      st_r.wake_cnt <= ssl_pkg::CNT_RST;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    low_side_delay_flag  = st_r.lo_flag;
    high_side_delay_flag = st_r.hi_flag;
    deep_sleep_state     = (st_r.pwr == ssl_pkg::SSL_SLEEP);
    cpu_hold             = (st_r.pwr != ssl_pkg::SSL_ACTIVE);
    slow_wake            = st_r.slow;
    hang_config          = st_r.hang;
    por_request          = st_r.por;
    low_sup_state        = st_r.ls;
    low_mon_state        = st_r.lm;
    high_sup_state       = st_r.hs;
    high_mon_state       = st_r.hm;
  end

endmodule

/* test/ssl_supervisor_lpm_asserts.sv */
`timescale 1ns/1ps
// ****************************************
// Checker
// ****************************************
module ssl_supervisor_lpm_asserts #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic ref_clk, srst, soft_power_up_clear, low_side_ctrl_wr,
  input wire logic low_supervisor_enable, low_supervisor_full_perf,
  input wire logic high_side_auto_control, high_supervisor_sleep_keep,
  input wire logic sleep_request, isr_return_sleep, wake_interrupt,
  input wire logic overvoltage_pin, overvoltage_protect_enable,
  input wire logic high_monitor_enable, low_side_delay_flag,
  input wire logic deep_sleep_state, cpu_hold, slow_wake, por_request,
  input wire logic [1:0] high_sup_state, high_mon_state
);
  logic [7:0] lcnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst || soft_power_up_clear);
  always_ff @(posedge ref_clk)
    if (srst || soft_power_up_clear) lcnt_r <= 8'h00;
    else if (low_side_ctrl_wr) lcnt_r <= 8'h01;
    else if (lcnt_r != 8'h00 && lcnt_r <= SETTLE_CYCLES + 1)
      lcnt_r <= lcnt_r + 8'h01;
  flag_len_a: assert property (
    low_side_delay_flag == (lcnt_r != 8'h00 && lcnt_r <= SETTLE_CYCLES + 1))
    else $error("low delay flag timing wrong");
  sleep_entry_a: assert property (
    (sleep_request || isr_return_sleep) && !wake_interrupt && !cpu_hold
    |=> deep_sleep_state) else $error("sleep not entered");
  wake_exit_a: assert property (
    deep_sleep_state && wake_interrupt |=> !deep_sleep_state && cpu_hold)
    else $error("wake not taken");
  slow_sel_a: assert property (1 |=> slow_wake ==
    ($past(low_supervisor_enable) && !$past(low_supervisor_full_perf)))
    else $error("wake speed wrong");
  clear_all_a: assert property (@(posedge ref_clk) disable iff (srst)
    soft_power_up_clear |=> !deep_sleep_state && !cpu_hold && !por_request)
    else $error("clear left state");
  keep_manual_a: assert property (
    $rose(deep_sleep_state) && !$past(high_side_auto_control) |->
    high_mon_state == $past(high_mon_state) && high_sup_state ==
    ($past(high_supervisor_sleep_keep) ? $past(high_sup_state) : 2'h0))
    else $error("manual sleep state wrong");
  auto_drop_a: assert property (
    $rose(deep_sleep_state) && $past(high_side_auto_control) |->
    high_mon_state == 2'h0)
    else $error("auto sleep state wrong");
  por_raise_a: assert property ((overvoltage_pin && !cpu_hold &&
    overvoltage_protect_enable && high_monitor_enable) [*4] |-> por_request)
    else $error("overvoltage reset missing");
endmodule
bind ssl_supervisor_lpm ssl_supervisor_lpm_asserts
  #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.*);

/* test/ssl_supervisor_lpm_tb.sv */
`timescale 1ns/1ps
module ssl_supervisor_lpm_tb;
  localparam int SET = 8;
  localparam int SLOW = 20;
  logic ref_clk = 1'b0, srst = 1'b1, soft_power_up_clear = 1'b0;
  logic low_side_ctrl_wr = 1'b0, high_side_ctrl_wr = 1'b0;
  logic sleep_request = 1'b0, isr_return_sleep = 1'b0;
  logic wake_interrupt = 1'b0, overvoltage_pin = 1'b0;
  logic overvoltage_protect_enable = 1'b0;
  logic [11:0] cfg = 12'h000;
  logic low_supervisor_enable, low_supervisor_sleep_keep;
  logic low_supervisor_full_perf, low_monitor_enable, low_monitor_full_perf;
  logic low_side_auto_control, high_supervisor_enable;
  logic high_supervisor_sleep_keep, high_supervisor_full_perf;
  logic high_monitor_enable, high_monitor_full_perf, high_side_auto_control;
  logic low_side_delay_flag, high_side_delay_flag, deep_sleep_state;
  logic cpu_hold, slow_wake, hang_config, por_request;
  logic [1:0] low_sup_state, low_mon_state, high_sup_state, high_mon_state;
  int err_total = 0, checks = 0, cyc = 0, n = 0;
  // Rows: config bits, slow wake, hang
  logic [13:0] rows [8] = '{{12'h000, 2'b00}, {12'h920, 2'b10},
    {12'hBA0, 2'b01}, {12'hBB0, 2'b00}, {12'hBB1, 2'b01},
    {12'hB85, 2'b01}, {12'hB84, 2'b00}, {12'h820, 2'b11}};
  assign {low_supervisor_enable, low_supervisor_sleep_keep,
    low_supervisor_full_perf, low_monitor_enable, low_monitor_full_perf,
    low_side_auto_control, high_supervisor_enable,
    high_supervisor_sleep_keep, high_supervisor_full_perf,
    high_monitor_enable, high_monitor_full_perf,
    high_side_auto_control} = cfg;
  ssl_supervisor_lpm #(.SETTLE_CYCLES(SET), .WAKE_SLOW_CYCLES(SLOW))
    dut_u (.*);
  always #2.5 ref_clk = ~ref_clk;
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task doze(input logic isr);
    @(posedge ref_clk);
    sleep_request <= !isr;
    isr_return_sleep <= isr;
    @(posedge ref_clk);
    sleep_request <= 1'b0;
    isr_return_sleep <= 1'b0;
    #1 chk("sleep", deep_sleep_state, 1'b1);
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      summarize();
    end
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      cfg <= rows[i][13:2];
      low_side_ctrl_wr <= 1'b1;
      high_side_ctrl_wr <= 1'b1;
      @(posedge ref_clk);
      low_side_ctrl_wr <= 1'b0;
      high_side_ctrl_wr <= 1'b0;
      @(posedge ref_clk);
      #1 chk("slow_wake", slow_wake, rows[i][1]);
      chk("hang_config", hang_config, rows[i][0]);
      chk("high_flag", high_side_delay_flag, 1'b1);
    end
    while ((low_side_delay_flag | high_side_delay_flag) !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("settle", n, SET);
    cfg <= 12'h93F;
    doze(1'b0);
    chk("auto_mon", high_mon_state, 2'h0);
    chk("auto_sup", high_sup_state, 2'h1);
    wake_interrupt <= 1'b1;
    @(posedge ref_clk);
    wake_interrupt <= 1'b0;
    #1 chk("early_wake", cpu_hold & !deep_sleep_state, 1'b1);
    repeat (SLOW + 4) @(posedge ref_clk);
    #1 chk("slow_wake_end", cpu_hold, 1'b0);
    chk("mon_back", high_mon_state, 2'h3);
    cfg <= 12'hBA4;
    repeat (2) @(posedge ref_clk);
    doze(1'b1);
    chk("man_sup", high_sup_state, 2'h0);
    chk("man_mon", high_mon_state, 2'h1);
    soft_power_up_clear <= 1'b1;
    @(posedge ref_clk);
    soft_power_up_clear <= 1'b0;
    #1 chk("clear", deep_sleep_state | cpu_hold, 1'b0);
    overvoltage_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 chk("por_off", por_request, 1'b0);
    overvoltage_protect_enable <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 chk("por_on", por_request, 1'b1);
    srst <= 1'b1;
    @(posedge ref_clk);
    #1 chk("rst_por", por_request, 1'b0);
    chk("rst_state", low_sup_state, 2'h0);
    summarize();
  end
endmodule
